// ==== hw/rtcal_alarm_control.sv ====
// Alarm control: enable, interval select, repeat counter, pulse, sync flag.
// Assumes the time-keeping core supplies per-unit match strobes and the
// prescaler position on core_clk; rtc_tick pulses once per real-time clock.
//
// The strobed register port and the register offsets were left to the implementer.
module rtcal_alarm_control #(
  parameter int PRESCALE_W = 15
) (
  // Clock and resets
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  por_done,
  // Host register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // Time-keeping core
  input  wire logic                  rtc_tick,
  input  wire logic [PRESCALE_W-1:0] prescale_count,
  input  wire logic                  half_sec_roll,
  input  wire logic [9:0]            match_units,
  input  wire logic                  date_is_feb29,
  input  wire logic                  year_is_leap,
  input  wire logic                  module_on,
  // Alarm outputs
  output logic                       alarm_pulse,
  output logic                       alarm_event,
  output logic                       irq
);

  // Control fields
  logic                  alarm_enable_r;
  logic                  chime_r;
  logic                  pulse_r;
  logic [3:0]            interval_r;
  logic [7:0]            repeat_r;
  logic                  unsafe_r;
  logic [1:0]            irq_status_r;
  logic [1:0]            irq_mask_r;
  logic                  event_nxt;
  logic                  wr_ctrl;
  logic [PRESCALE_W-1:0] to_roll;

  assign wr_ctrl = reg_wr && (reg_addr == rtcal_pkg::ADDR_ALARM_CONTROL);

  // Maps an interval code onto its match strobe
  function automatic logic interval_hit(input logic [3:0] code, input logic [9:0] m,
                                        input logic feb29, input logic leap);
    logic hit;
    hit = 1'b0;
    case (code)
      rtcal_pkg::RTCAL_HALF_SEC: hit = m[0];
      rtcal_pkg::RTCAL_ONE_SEC:  hit = m[1];
      rtcal_pkg::RTCAL_TEN_SEC:  hit = m[2];
      rtcal_pkg::RTCAL_ONE_MIN:  hit = m[3];
      rtcal_pkg::RTCAL_TEN_MIN:  hit = m[4];
      rtcal_pkg::RTCAL_HOURLY:   hit = m[5];
      rtcal_pkg::RTCAL_DAILY:    hit = m[6];
      rtcal_pkg::RTCAL_WEEKLY:   hit = m[7];
      rtcal_pkg::RTCAL_MONTHLY:  hit = m[8];
      rtcal_pkg::RTCAL_YEARLY:   hit = m[9] && (!feb29 || leap);
      default:                   hit = 1'b0;
    endcase
    return hit;
  endfunction

  assign event_nxt = alarm_enable_r && interval_hit(interval_r, match_units,
                                                    date_is_feb29, year_is_leap);
  assign alarm_event = event_nxt;

  // Power-on only reset
  // Soft resets never reach this block; rst is the power-on reset alone.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_enable_r <= 1'b0;
    end else if (event_nxt && (repeat_r == rtcal_pkg::REPEAT_ZERO) && !chime_r) begin
      // Auto disable
      // Hardware clear wins over a same-cycle software write.
      alarm_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      alarm_enable_r <= reg_wdata[rtcal_pkg::BIT_ALARM_ENABLE];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chime_r    <= 1'b0;
      interval_r <= 4'h0;
    end else if (wr_ctrl) begin
      chime_r    <= reg_wdata[rtcal_pkg::BIT_CHIME];
      interval_r <= reg_wdata[rtcal_pkg::INTERVAL_LSB +: rtcal_pkg::INTERVAL_W];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      repeat_r <= 8'h00;
    end else if (event_nxt) begin
      if (repeat_r != rtcal_pkg::REPEAT_ZERO) begin
        repeat_r <= repeat_r - 8'h01;
      end else if (chime_r) begin
        repeat_r <= rtcal_pkg::REPEAT_MAX;
      end else begin
        repeat_r <= rtcal_pkg::REPEAT_ZERO;
      end
    end else if (wr_ctrl) begin
      repeat_r <= reg_wdata[rtcal_pkg::REPEAT_LSB +: rtcal_pkg::REPEAT_W];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulse_r <= 1'b0;
    end else if (event_nxt) begin
      pulse_r <= ~pulse_r;
    end else if (wr_ctrl && !alarm_enable_r) begin
      pulse_r <= reg_wdata[rtcal_pkg::BIT_PIV];
    end
  end
  assign alarm_pulse = pulse_r;

  assign to_roll = prescale_count;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      unsafe_r <= 1'b0;
    end else if (to_roll <= PRESCALE_W'(rtcal_pkg::SYNC_GUARD_TICKS) || half_sec_roll) begin
      unsafe_r <= 1'b1;
    end else if (rtc_tick) begin
      unsafe_r <= 1'b0;
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_status_r <= 2'h0;
    end else begin
      irq_status_r <= (irq_status_r
                       & ~((reg_wr && reg_addr == rtcal_pkg::ADDR_IRQ_STATUS)
                           ? reg_wdata[1:0] : 2'h0))
                      | {event_nxt && (repeat_r == rtcal_pkg::REPEAT_ZERO) && !chime_r,
                         event_nxt};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_mask_r <= 2'h0;
    end else if (reg_wr && reg_addr == rtcal_pkg::ADDR_IRQ_MASK) begin
      irq_mask_r <= reg_wdata[1:0];
    end
  end
  assign irq = |(irq_status_r & irq_mask_r);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        rtcal_pkg::ADDR_ALARM_CONTROL:
          reg_rdata <= {16'h0000, alarm_enable_r, chime_r, pulse_r, unsafe_r,
                        interval_r, repeat_r};
        rtcal_pkg::ADDR_IRQ_STATUS: reg_rdata <= {30'h0, irq_status_r};
        rtcal_pkg::ADDR_IRQ_MASK:   reg_rdata <= {30'h0, irq_mask_r};
        rtcal_pkg::ADDR_TIME_STATUS:
          reg_rdata <= {29'h0, module_on, por_done, year_is_leap};
        default:                    reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Assertions
  a_event_needs_enable: assert property (@(posedge core_clk) disable iff (rst)
    alarm_event |-> alarm_enable_r) else $error("event while disabled");

  a_chime_wraps: assert property (@(posedge core_clk) disable iff (rst)
    (event_nxt && chime_r && repeat_r == 8'h00) |=> repeat_r == 8'hFF)
    else $error("no wrap");

  a_halt_zero: assert property (@(posedge core_clk) disable iff (rst)
    (event_nxt && !chime_r && repeat_r == 8'h00) |=> repeat_r == 8'h00)
    else $error("count moved past zero");

  a_piv_load: assert property (@(posedge core_clk) disable iff (rst)
    (wr_ctrl && !alarm_enable_r && !event_nxt) |=> alarm_pulse == $past(reg_wdata[13]))
    else $error("pulse not loaded");

  a_piv_locked: assert property (@(posedge core_clk) disable iff (rst)
    (alarm_enable_r && !event_nxt) |=> alarm_pulse == $past(alarm_pulse))
    else $error("pulse changed while enabled");

  a_sync_near: assert property (@(posedge core_clk) disable iff (rst)
    (prescale_count <= 15'd32) |=> unsafe_r) else $error("flag not set");

  a_auto_off: assert property (@(posedge core_clk) disable iff (rst)
    (event_nxt && repeat_r == 8'h00 && !chime_r) |=> !alarm_enable_r)
    else $error("enable not cleared");

  a_count_dec: assert property (@(posedge core_clk) disable iff (rst)
    (event_nxt && repeat_r != 8'h00) |=> repeat_r == $past(repeat_r) - 8'h01)
    else $error("count not decremented");

  a_leap_gate: assert property (@(posedge core_clk) disable iff (rst)
    (interval_r == 4'h9 && date_is_feb29 && !year_is_leap) |-> !alarm_event)
    else $error("feb29 alarm off-leap");

  a_leap_allows: assert property (@(posedge core_clk) disable iff (rst)
    (alarm_enable_r && interval_r == rtcal_pkg::RTCAL_YEARLY
     && match_units[9] && year_is_leap)
    |-> alarm_event)
    else $error("leap year alarm missing");

  a_sync_roll: assert property (@(posedge core_clk) disable iff (rst)
    half_sec_roll
    |=> unsafe_r)
    else $error("flag not set on rollover");

  a_sync_hold: assert property (@(posedge core_clk) disable iff (rst)
    (unsafe_r && !rtc_tick)
    |=> unsafe_r)
    else $error("flag cleared between ticks");

  a_sync_read: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == rtcal_pkg::ADDR_ALARM_CONTROL)
    |=> reg_rdata[rtcal_pkg::BIT_UNSAFE] == $past(unsafe_r))
    else $error("flag not shown on read");

  a_upper_zero: assert property (@(posedge core_clk) disable iff (rst)
    1'b1
    |-> reg_rdata[31:16] == 16'h0000)
    else $error("upper bits not zero");

  a_idle_rdata: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd
    |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  a_reserved_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (interval_r > rtcal_pkg::RTCAL_YEARLY)
    |-> !alarm_event)
    else $error("event on reserved interval");

  a_interval_hold: assert property (@(posedge core_clk) disable iff (rst)
    !wr_ctrl
    |=> $stable(interval_r))
    else $error("interval changed without write");

  a_enable_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_ctrl && !event_nxt)
    |=> alarm_enable_r == $past(reg_wdata[rtcal_pkg::BIT_ALARM_ENABLE]))
    else $error("enable not written");

  a_enable_hold: assert property (@(posedge core_clk) disable iff (rst)
    (!wr_ctrl && !event_nxt)
    |=> $stable(alarm_enable_r))
    else $error("enable changed on its own");

  a_count_hold: assert property (@(posedge core_clk) disable iff (rst)
    (!wr_ctrl && !event_nxt)
    |=> $stable(repeat_r))
    else $error("count changed on its own");

  a_pulse_toggle: assert property (@(posedge core_clk) disable iff (rst)
    event_nxt
    |=> alarm_pulse != $past(alarm_pulse))
    else $error("pulse not toggled");

  a_event_status: assert property (@(posedge core_clk) disable iff (rst)
    event_nxt
    |=> irq_status_r[rtcal_pkg::IRQ_ALARM])
    else $error("event status not set");

  a_auto_status: assert property (@(posedge core_clk) disable iff (rst)
    (event_nxt && repeat_r == rtcal_pkg::REPEAT_ZERO && !chime_r)
    |=> irq_status_r[rtcal_pkg::IRQ_DISABLED])
    else $error("disable status not set");

  a_status_sticky: assert property (@(posedge core_clk) disable iff (rst)
    (irq_status_r[rtcal_pkg::IRQ_ALARM]
     && !(reg_wr && reg_addr == rtcal_pkg::ADDR_IRQ_STATUS))
    |=> irq_status_r[rtcal_pkg::IRQ_ALARM])
    else $error("status bit lost");

  a_status_clear: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == rtcal_pkg::ADDR_IRQ_STATUS
     && reg_wdata[rtcal_pkg::IRQ_ALARM] && !event_nxt)
    |=> !irq_status_r[rtcal_pkg::IRQ_ALARM])
    else $error("status bit not cleared");

  a_mask_gate: assert property (@(posedge core_clk) disable iff (rst)
    (irq_mask_r == 2'h0)
    |-> !irq)
    else $error("masked interrupt raised");
endmodule

// ==== hw/rtcal_pkg.sv ====
// Constants for the alarm control block of the real-time clock.
// Assumes one core clock and a host port with one-cycle read latency.
package rtcal_pkg;
  // Register map, word addresses on the host port
  localparam logic [3:0] ADDR_ALARM_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS    = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK      = 4'h2;
  localparam logic [3:0] ADDR_TIME_STATUS   = 4'h3;

  // Field positions of alarm_control
  localparam int BIT_ALARM_ENABLE  = 15;
  localparam int BIT_CHIME         = 14;
  localparam int BIT_PIV           = 13;
  localparam int BIT_UNSAFE        = 12;
  localparam int INTERVAL_LSB      = 8;
  localparam int INTERVAL_W        = 4;
  localparam int REPEAT_LSB        = 0;
  localparam int REPEAT_W          = 8;

  localparam logic [7:0] REPEAT_ZERO = 8'h00;
  localparam logic [7:0] REPEAT_MAX  = 8'hFF;

  // Interrupt status bits
  localparam int IRQ_ALARM    = 0;
  localparam int IRQ_DISABLED = 1;
  localparam int IRQ_W        = 2;

  // Sync window, in real-time clock periods before a half-second rollover
  localparam int SYNC_GUARD_TICKS = 32;

  // Alarm interval codes
  typedef enum logic [3:0] {
    RTCAL_HALF_SEC  = 4'h0,
    RTCAL_ONE_SEC   = 4'h1,
    RTCAL_TEN_SEC   = 4'h2,
    RTCAL_ONE_MIN   = 4'h3,
    RTCAL_TEN_MIN   = 4'h4,
    RTCAL_HOURLY    = 4'h5,
    RTCAL_DAILY     = 4'h6,
    RTCAL_WEEKLY    = 4'h7,
    RTCAL_MONTHLY   = 4'h8,
    RTCAL_YEARLY    = 4'h9
  } rtcal_interval_t;
endpackage

// ==== dv/tb_rtcal_alarm_control.sv ====
// Self-checking bench for the alarm control block.
// Assumes the host port of the package map and one core clock at 200 MHz.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_rtcal_alarm_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        rtc_tick = 1'b0;
  logic        half_sec_roll = 1'b0;
  logic [31:0] d_prev;
  logic [14:0] prescale_count = 15'h0064;
  logic [9:0]  match_units = 10'h000;
  logic        date_is_feb29 = 1'b0;
  logic        year_is_leap = 1'b0;
  logic        alarm_pulse;
  logic        alarm_event;
  logic        irq;
  logic        ev;
  logic [31:0] d;
  int          fail_count = 0;
  int          n_checks = 0;
  rtcal_alarm_control DUT (.core_clk(core_clk), .rst(rst), .por_done(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rtc_tick(rtc_tick), .prescale_count(prescale_count),
    .half_sec_roll(half_sec_roll), .match_units(match_units), .date_is_feb29(date_is_feb29),
    .year_is_leap(year_is_leap), .module_on(1'b1), .alarm_pulse(alarm_pulse),
    .alarm_event(alarm_event), .irq(irq));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // One match strobe; event output sampled while the strobe stands
  task automatic fire(input int u);
    @(posedge core_clk);
    match_units <= 10'(1 << u);
    #1 ev = alarm_event;
    @(posedge core_clk);
    match_units <= 10'h000;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic tick(input logic [14:0] p);
    @(posedge core_clk);
    prescale_count <= p; rtc_tick <= 1'b1;
    @(posedge core_clk);
    rtc_tick <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Generous bound: the sequence needs well under 2000 cycles
  initial begin
    #20us;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(4'h0); `CHK(d, 32'h0000_0000)
    wr(4'h0, 32'hFFFF_2103); rd(4'h0); `CHK(d, 32'h0000_2103)
    `CHK(alarm_pulse, 1'b1)
    wr(4'h0, 32'h0000_A103); wr(4'h0, 32'h0000_8103);
    rd(4'h0); `CHK(d, 32'h0000_A103)
    fire(1); rd(4'h0); `CHK(d, 32'h0000_8102)
    $display("test register and pulse done");
    rd(4'h1); `CHK(d, 32'h0000_0001)
    `CHK(irq, 1'b0)
    wr(4'h2, 32'h0000_0001); #1 `CHK(irq, 1'b1)
    wr(4'h2, 32'h0000_0000); wr(4'h1, 32'h0000_0001);
    rd(4'h1); `CHK(d, 32'h0000_0000)
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    fire(1); fire(1); rd(4'h0); `CHK(d & 32'hFFFF_DFFF, 32'h0000_8100)
    fire(1); rd(4'h0); `CHK(d & 32'hFFFF_DFFF, 32'h0000_0100)
    rd(4'h1); `CHK(d & 32'h0000_0002, 32'h0000_0002)
    fire(1); `CHK(ev, 1'b0)
    rd(4'h0); `CHK(d & 32'hFFFF_DFFF, 32'h0000_0100)
    $display("test countdown done");
    // Every interval code: its own match strobe counts, the next code's strobe does not
    for (int c = 0; c < 10; c++) begin
      wr(4'h0, 32'h0000_C010 | 32'(c << 8));
      fire((c + 1) % 10); `CHK(ev, 1'b0)
      fire(c); `CHK(ev, 1'b1)
      rd(4'h0); `CHK(d & 32'hFFFF_DFFF, 32'h0000_C00F | 32'(c << 8))
    end
    $display("test intervals done");
    wr(4'h0, 32'h0000_C000); fire(0);
    rd(4'h0); `CHK(d & 32'hFFFF_DFFF, 32'h0000_C0FF)
    wr(4'h0, 32'h0000_C910); date_is_feb29 <= 1'b1;
    fire(9); `CHK(ev, 1'b0)
    year_is_leap <= 1'b1;
    fire(9); `CHK(ev, 1'b1)
    $display("test wrap and leap done");
    tick(15'h0020); rd(4'h0); `CHK(d & 32'h0000_1000, 32'h0000_1000)
    // No control writes while the flag is set
    d_prev = d; rd(4'h0); `CHK(d[7:0], d_prev[7:0])
    tick(15'h0021); rd(4'h0); `CHK(d & 32'h0000_1000, 32'h0000_0000)
    @(posedge core_clk);
    half_sec_roll <= 1'b1;
    @(posedge core_clk);
    half_sec_roll <= 1'b0;
    rd(4'h0); `CHK(d & 32'h0000_1000, 32'h0000_1000)
    tick(15'h0021); rd(4'h0); `CHK(d & 32'h0000_1000, 32'h0000_0000)
    rd(4'hF); `CHK(d, 32'h0000_0000)
    $display("test sync and unmapped done");
    tally_and_finish();
  end
endmodule
